// ### design/afe_config_regs.sv
`timescale 1ns/1ps
// Contract
// - Bit 0 of the tristate register chooses floating or driven pixel data outputs.
// - A zero in the pixel or sync tristate bit floats that group, a one drives it.
// - The bias register picks half or full current for each of seven analog stages.
// - Bias selections act only while the bias-generator enable bit is set.
// - Bias bits 6 to 0 map converter, global offset, gain B, gain A, white balance, column offset, clamp.
// - A bias bit at zero means full current, and all bias bits reset to zero.
// - Each global gain register holds a 6-bit code in bits 5 to 0, bits 7 and 6 unused.
// - The global gain code is applied alike to every pixel of the frame.
// - In raw or linear exposure mode both gain registers A and B are used.
// - In the second linear mode only gain A is used and gain B is ignored.
// - Both global gain registers reset to code 001110.
// - White balance gain offers a raw and a linear mode.
// - Exposure gain offers raw, linear and second linear modes.
// - Raw mode steps 32 fine then 32 coarse steps, linear mode has 48 steps.
// - Gain mode bits 1 to 0 give 00 raw, 01 linear, 1x second linear, bit 2 white balance.
module afe_config_regs
   import afe_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h33
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output afe_ctrl_type ctrl
);

   // ************************************************************
   // State
   // ************************************************************
   // DEV_ADDR is an arbitrary value.
   localparam afe_state_type STATE_RST = '{
      st: ST_IDLE, cnt: 3'h0, full: 1'b0, rw: 1'b0, nack: 1'b0, sh: 8'h00,
      ptr: 8'h00, scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0,
      power_config: PWR_CFG_RST, exposure_global_gain_a: GAIN_RST,
      output_tristate_control: TRISTATE_RST, stage_bias_select: BIAS_RST,
      exposure_global_gain_b: GAIN_RST, gain_mode: GAIN_MODE_RST,
      // Controls leave reset matching the register reset values, so nothing jumps at release.
      ctrl: '{pix_drive: TRISTATE_RST[TS_PIX_BIT], sync_drive: TRISTATE_RST[TS_SYNC_BIT],
         bias_gen_en: PWR_CFG_RST[PWR_BIAS_GEN_BIT], bias_half: 7'h00,
         global_gain_code_a: GAIN_RST[5:0], global_gain_code_b: GAIN_RST[5:0],
         exp_gain_mode: GAIN_MODE_RST[1:0], wb_linear: GAIN_MODE_RST[WB_MODE_BIT]}};
   afe_state_type state_reg;
   afe_state_type state_next;
   logic start_cond;
   logic stop_cond;
   logic scl_rise;
   logic scl_fall;
   logic [7:0] rd_data;
   assign sda_out = 1'b0;
   assign sda_oe = state_reg.sda_oe;
   assign ctrl = state_reg.ctrl;
   always_comb
   begin
      state_next = state_reg;
      rd_data = 8'h00;
      start_cond = scl_in && state_reg.scl_q && state_reg.sda_q && !sda_in;
      stop_cond = scl_in && state_reg.scl_q && !state_reg.sda_q && sda_in;
      scl_rise = scl_in && !state_reg.scl_q;
      scl_fall = !scl_in && state_reg.scl_q;
      state_next.scl_q = scl_in;
      state_next.sda_q = sda_in;

      // ************************************************************
      // Serial control port
      // ************************************************************
      // zero unused bits
      if (state_reg.ptr == PWR_CFG_OFS)
         rd_data = state_reg.power_config & PWR_CFG_MASK;
      else if (state_reg.ptr == GAIN_A_OFS)
         rd_data = state_reg.exposure_global_gain_a & GAIN_MASK;
      else if (state_reg.ptr == TRISTATE_OFS)
         rd_data = state_reg.output_tristate_control & TRISTATE_MASK;
      else if (state_reg.ptr == BIAS_OFS)
         rd_data = state_reg.stage_bias_select & BIAS_MASK;
      else if (state_reg.ptr == GAIN_B_OFS)
         rd_data = state_reg.exposure_global_gain_b & GAIN_MASK;
      else if (state_reg.ptr == GAIN_MODE_OFS)
         rd_data = state_reg.gain_mode & GAIN_MODE_MASK;
      // A start or stop is honoured in any state so a lost host can always resync.
      if (start_cond)
      begin
         state_next.st = ST_DEV;
         state_next.cnt = 3'h0;
         state_next.full = 1'b0;
         state_next.sda_oe = 1'b0;
      end
      else if (stop_cond)
      begin
         state_next.st = ST_IDLE;
         state_next.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         case (state_reg.st)
            ST_DEV, ST_SUB, ST_WR:
            begin
               state_next.sh = {state_reg.sh[6:0], sda_in};
               state_next.cnt = state_reg.cnt + 3'h1;
               state_next.full = (state_reg.cnt == BIT_CNT_LAST);
            end
            ST_RD: state_next.cnt = state_reg.cnt + 3'h1;
            ST_RD_ACK: state_next.nack = sda_in;
            default: state_next.st = state_reg.st;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_reg.st)
            ST_DEV:
               if (state_reg.full)
               begin
                  state_next.full = 1'b0;
                  if (state_reg.sh[7:1] == DEV_ADDR)
                  begin
                     state_next.st = ST_DEV_ACK;
                     state_next.rw = state_reg.sh[0];
                     state_next.sda_oe = 1'b1;
                  end
                  else
                     state_next.st = ST_IDLE;
               end
            ST_DEV_ACK:
               if (state_reg.rw)
               begin
                  state_next.st = ST_RD;
                  state_next.sh = rd_data;
                  state_next.cnt = 3'h0;
                  state_next.sda_oe = !rd_data[7];
               end
               else
               begin
                  state_next.st = ST_SUB;
                  state_next.sda_oe = 1'b0;
               end
            ST_SUB:
               if (state_reg.full)
               begin
                  state_next.full = 1'b0;
                  state_next.ptr = state_reg.sh;
                  state_next.st = ST_SUB_ACK;
                  state_next.sda_oe = 1'b1;
               end
            ST_WR:
               if (state_reg.full)
               begin
                  state_next.full = 1'b0;
                  state_next.ptr = state_reg.ptr + 8'h01;
                  state_next.st = ST_WR_ACK;
                  state_next.sda_oe = 1'b1;
                  if (state_reg.ptr == PWR_CFG_OFS)
                     state_next.power_config = state_reg.sh & PWR_CFG_MASK;
                  else if (state_reg.ptr == GAIN_A_OFS)
                     state_next.exposure_global_gain_a = state_reg.sh & GAIN_MASK;
                  else if (state_reg.ptr == TRISTATE_OFS)
                     state_next.output_tristate_control = state_reg.sh & TRISTATE_MASK;
                  else if (state_reg.ptr == BIAS_OFS)
                     state_next.stage_bias_select = state_reg.sh & BIAS_MASK;
                  else if (state_reg.ptr == GAIN_B_OFS)
                     state_next.exposure_global_gain_b = state_reg.sh & GAIN_MASK;
                  else if (state_reg.ptr == GAIN_MODE_OFS)
                     state_next.gain_mode = state_reg.sh & GAIN_MODE_MASK;
               end
            ST_SUB_ACK, ST_WR_ACK:
            begin
               state_next.st = ST_WR;
               state_next.sda_oe = 1'b0;
            end
            ST_RD:
               if (state_reg.cnt == 3'h0)
               begin
                  state_next.st = ST_RD_ACK;
                  state_next.sda_oe = 1'b0;
                  state_next.ptr = state_reg.ptr + 8'h01;
               end
               else
               begin
                  state_next.sh = {state_reg.sh[6:0], 1'b0};
                  state_next.sda_oe = !state_reg.sh[6];
               end
            ST_RD_ACK:
               if (state_reg.nack)
                  state_next.st = ST_IDLE;
               else
               begin
                  state_next.st = ST_RD;
                  state_next.sh = rd_data;
                  state_next.cnt = 3'h0;
                  state_next.sda_oe = !rd_data[7];
               end
            default: state_next.st = state_reg.st;
         endcase
      end

      // ************************************************************
      // Analog chain controls
      // ************************************************************
      // pixel bus drive
      state_next.ctrl.pix_drive = state_reg.output_tristate_control[TS_PIX_BIT];
      state_next.ctrl.sync_drive = state_reg.output_tristate_control[TS_SYNC_BIT];
      state_next.ctrl.bias_gen_en = state_reg.power_config[PWR_BIAS_GEN_BIT];
      // gate by enable
      // Disabled generator keeps every stage at full current rather than a stale choice.
      if (state_reg.power_config[PWR_BIAS_GEN_BIT])
         state_next.ctrl.bias_half = state_reg.stage_bias_select[6:0];
      else
         state_next.ctrl.bias_half = 7'h00;
      state_next.ctrl.global_gain_code_a = state_reg.exposure_global_gain_a[5:0];
      state_next.ctrl.exp_gain_mode = state_reg.gain_mode[1:0];
      state_next.ctrl.wb_linear = state_reg.gain_mode[WB_MODE_BIT];
      if (state_reg.gain_mode[1])
         state_next.ctrl.global_gain_code_b = 6'h00;
      else
         state_next.ctrl.global_gain_code_b = state_reg.exposure_global_gain_b[5:0];
   end
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         state_reg <= STATE_RST;
      else
         state_reg <= state_next;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_gain_b_ignored;
      state_reg.gain_mode[1] ##1 (ctrl.global_gain_code_b == 6'h00);
   endsequence
   property p_pix_drive;
      @(posedge mclk) disable iff (!nrst)
      1'b1 |=> (ctrl.pix_drive == $past(state_reg.output_tristate_control[0]));
   endproperty
   a_pix_drive: assert property (p_pix_drive) else $error("pixel drive mismatch");
   property p_sync_drive;
      @(posedge mclk) disable iff (!nrst)
      $fell(state_reg.output_tristate_control[1]) |=> !ctrl.sync_drive;
   endproperty
   a_sync_drive: assert property (p_sync_drive) else $error("sync group not floated");
   property p_bias_gate;
      @(posedge mclk) disable iff (!nrst)
      !state_reg.power_config[4] |=> (ctrl.bias_half == 7'h00);
   endproperty
   a_bias_gate: assert property (p_bias_gate) else $error("bias used while disabled");
   property p_bias_pass;
      @(posedge mclk) disable iff (!nrst)
      state_reg.power_config[4] |=> (ctrl.bias_half == $past(state_reg.stage_bias_select[6:0]));
   endproperty
   a_bias_pass: assert property (p_bias_pass) else $error("bias select not applied");
   property p_bias_unused;
      @(posedge mclk) disable iff (!nrst)
      !state_reg.stage_bias_select[7];
   endproperty
   a_bias_unused: assert property (p_bias_unused) else $error("bias bit 7 set");
   property p_gain_unused;
      @(posedge mclk) disable iff (!nrst)
      (state_reg.exposure_global_gain_a[7:6] == 2'h0) &&
      (state_reg.exposure_global_gain_b[7:6] == 2'h0);
   endproperty
   a_gain_unused: assert property (p_gain_unused) else $error("gain upper bits set");
   property p_gain_a_out;
      @(posedge mclk) disable iff (!nrst)
      1'b1 |=> (ctrl.global_gain_code_a == $past(state_reg.exposure_global_gain_a[5:0]));
   endproperty
   a_gain_a_out: assert property (p_gain_a_out) else $error("gain A not applied");
   property p_gain_b_used;
      @(posedge mclk) disable iff (!nrst)
      !state_reg.gain_mode[1] |=>
         (ctrl.global_gain_code_b == $past(state_reg.exposure_global_gain_b[5:0]));
   endproperty
   a_gain_b_used: assert property (p_gain_b_used) else $error("gain B not applied");
   property p_gain_b_ignored;
      @(posedge mclk) disable iff (!nrst)
      state_reg.gain_mode[1] |-> s_gain_b_ignored;
   endproperty
   a_gain_b_ignored: assert property (p_gain_b_ignored) else $error("gain B leaked");
   property p_mode_out;
      @(posedge mclk) disable iff (!nrst)
      1'b1 |=> (ctrl.exp_gain_mode == $past(state_reg.gain_mode[1:0])) &&
         (ctrl.wb_linear == $past(state_reg.gain_mode[2]));
   endproperty
   a_mode_out: assert property (p_mode_out) else $error("gain mode mismatch");
endmodule // afe_config_regs

// ### pkg/afe_pkg.sv
package afe_pkg;

   // ************************************************************
   // Register offsets on the serial control port
   // ************************************************************
   localparam logic [7:0] PWR_CFG_OFS = 8'h0D;
   localparam logic [7:0] GAIN_A_OFS = 8'h10;
   localparam logic [7:0] TRISTATE_OFS = 8'h12;
   localparam logic [7:0] BIAS_OFS = 8'h13;
   localparam logic [7:0] GAIN_B_OFS = 8'h21;
   localparam logic [7:0] GAIN_MODE_OFS = 8'h22;

   // ************************************************************
   // Writable bit masks and field positions
   // ************************************************************
   localparam logic [7:0] PWR_CFG_MASK = 8'h10;
   localparam logic [7:0] GAIN_MASK = 8'h3F;
   localparam logic [7:0] TRISTATE_MASK = 8'h03;
   localparam logic [7:0] BIAS_MASK = 8'h7F;
   localparam logic [7:0] GAIN_MODE_MASK = 8'h07;
   localparam int PWR_BIAS_GEN_BIT = 4;
   localparam int TS_PIX_BIT = 0;
   localparam int TS_SYNC_BIT = 1;
   localparam int WB_MODE_BIT = 2;
   localparam int BIAS_CONVERTER_BIT = 6;
   localparam int BIAS_GLOBAL_OFFSET_BIT = 5;
   localparam int BIAS_GAIN_B_BIT = 4;
   localparam int BIAS_GAIN_A_BIT = 3;
   localparam int BIAS_WHITE_BAL_BIT = 2;
   localparam int BIAS_COL_OFFSET_BIT = 1;
   localparam int BIAS_FRAME_CLAMP_BIT = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] PWR_CFG_RST = 8'h00;
   localparam logic [7:0] GAIN_RST = 8'h0E;
   localparam logic [7:0] TRISTATE_RST = 8'h00;
   localparam logic [7:0] BIAS_RST = 8'h00;
   localparam logic [7:0] GAIN_MODE_RST = 8'h00;

   // ************************************************************
   // Gain modes and step counts of the analog amplifiers
   // ************************************************************
   localparam logic [1:0] EXP_MODE_RAW = 2'h0;
   localparam logic [1:0] EXP_MODE_LINEAR = 2'h1;
   localparam int RAW_FINE_STEPS = 32;
   localparam int RAW_COARSE_STEPS = 32;
   localparam int LINEAR_STEPS = 48;
   localparam int LINEAR2_STEPS = 64;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_DEV = 9'h002,
      ST_DEV_ACK = 9'h004,
      ST_SUB = 9'h008,
      ST_SUB_ACK = 9'h010,
      ST_WR = 9'h020,
      ST_WR_ACK = 9'h040,
      ST_RD = 9'h080,
      ST_RD_ACK = 9'h100
   } afe_bus_state_type;

   typedef struct packed {
      logic pix_drive;
      logic sync_drive;
      logic bias_gen_en;
      logic [6:0] bias_half;
      logic [5:0] global_gain_code_a;
      logic [5:0] global_gain_code_b;
      logic [1:0] exp_gain_mode;
      logic wb_linear;
   } afe_ctrl_type;

   typedef struct packed {
      afe_bus_state_type st;
      logic [2:0] cnt;
      logic full;
      logic rw;
      logic nack;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic [7:0] power_config;
      logic [7:0] exposure_global_gain_a;
      logic [7:0] output_tristate_control;
      logic [7:0] stage_bias_select;
      logic [7:0] exposure_global_gain_b;
      logic [7:0] gain_mode;
      afe_ctrl_type ctrl;
   } afe_state_type;

endpackage

// ### tb/afe_host_model.sv
`timescale 1ns/1ps
module afe_host_model
   import afe_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h33
)
(
   input wire logic mclk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // ************************************************************
   // Serial host: each SCL phase is held well above two clocks.
   // ************************************************************
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Also serves as a repeated start, since SDA is released while SCL is still low.
   task automatic bus_start();
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   task automatic bus_stop();
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask

   task automatic bit_cycle(input logic b, output logic r);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = sda_line;
      scl <= 1'b0;
      tick(2);
   endtask

   // A released line reads high through the pull-up, so a missing answer reads as NACK.
   task automatic byte_xfer(input logic [7:0] tx, input logic host_ack, output logic [7:0] rx,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cycle(tx[i], r);
         rx[i] = r;
      end
      bit_cycle(~host_ack, r);
      ack = ~r;
   endtask

   task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
      output logic acked);
      logic [7:0] rx;
      logic a0;
      logic a1;
      logic a2;
      bus_start();
      byte_xfer({dev, 1'b0}, 1'b0, rx, a0);
      if (a0)
      begin
         byte_xfer(ofs, 1'b0, rx, a1);
         byte_xfer(d, 1'b0, rx, a2);
      end
      bus_stop();
      acked = a0 & a1 & a2;
   endtask

   task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
      logic [7:0] rx;
      logic a;
      bus_start();
      byte_xfer({DEV_ADDR, 1'b0}, 1'b0, rx, a);
      byte_xfer(ofs, 1'b0, rx, a);
      bus_start();
      byte_xfer({DEV_ADDR, 1'b1}, 1'b0, rx, a);
      byte_xfer(8'hFF, 1'b0, d, a);
      bus_stop();
   endtask
endmodule // afe_host_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
   import afe_pkg::*;
   localparam logic [6:0] DEV = 7'h33;
   localparam int LIMIT = 60000;
   logic mclk;
   logic nrst;
   logic scl;
   logic sda_low;
   logic sda_line;
   logic sda_out;
   logic sda_oe;
   afe_ctrl_type ctrl;
   int mismatches;
   int checked;
   int cycles;

   // ************************************************************
   // Clock, wire and instances
   // ************************************************************
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   // Open drain with pull-up: either party pulling low wins.
   assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

   afe_config_regs #(.DEV_ADDR(DEV)) u_afe_config_regs (.mclk(mclk), .nrst(nrst),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl));

   afe_host_model #(.DEV_ADDR(DEV)) u_afe_host_model (.mclk(mclk), .sda_line(sda_line),
      .scl(scl), .sda_low(sda_low));

   // ************************************************************
   // Report
   // ************************************************************
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic a;
      u_afe_host_model.wr_reg(DEV, ofs, d, a);
      check_val("write ack", 8'h01, {7'h00, a});
   endtask

   task automatic rd_check(input string name, input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      u_afe_host_model.rd_reg(ofs, d);
      check_val(name, exp, d);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values();
      check_val("gain a code", 8'h0E, {2'h0, ctrl.global_gain_code_a});
      check_val("gain b code", 8'h0E, {2'h0, ctrl.global_gain_code_b});
      check_val("bias half", 8'h00, {1'h0, ctrl.bias_half});
      check_val("reset floating", 8'h00, {6'h00, ctrl.sync_drive, ctrl.pix_drive});
      rd_check("tristate reg rst", TRISTATE_OFS, 8'h00);
      rd_check("gain a reg", GAIN_A_OFS, 8'h0E);
      rd_check("gain b reg", GAIN_B_OFS, 8'h0E);
      rd_check("bias reg", BIAS_OFS, 8'h00);
      rd_check("mode reg", GAIN_MODE_OFS, 8'h00);
   endtask

   task automatic t_tristate();
      wr(TRISTATE_OFS, 8'hFF);
      rd_check("tristate reg", TRISTATE_OFS, 8'h03);
      check_val("both driven", 8'h03, {6'h00, ctrl.sync_drive, ctrl.pix_drive});
      wr(TRISTATE_OFS, 8'h01);
      check_val("pixel only", 8'h01, {6'h00, ctrl.sync_drive, ctrl.pix_drive});
      wr(TRISTATE_OFS, 8'h02);
      check_val("sync only", 8'h02, {6'h00, ctrl.sync_drive, ctrl.pix_drive});
      wr(TRISTATE_OFS, 8'h00);
      check_val("floating", 8'h00, {6'h00, ctrl.sync_drive, ctrl.pix_drive});
   endtask

   task automatic t_bias();
      wr(BIAS_OFS, 8'hFF);
      rd_check("bias reg", BIAS_OFS, 8'h7F);
      check_val("bias gen off", 8'h00, {1'h0, ctrl.bias_half});
      check_val("gen enable off", 8'h00, {7'h00, ctrl.bias_gen_en});
      // Software enables the bias generator before it relies on the selections.
      wr(PWR_CFG_OFS, 8'hFF);
      rd_check("power reg", PWR_CFG_OFS, 8'h10);
      check_val("gen enable on", 8'h01, {7'h00, ctrl.bias_gen_en});
      check_val("bias gen on", 8'h7F, {1'h0, ctrl.bias_half});
      for (int i = 0; i < 7; i++)
      begin
         wr(BIAS_OFS, 8'h01 << i);
         check_val("stage half", 8'h01 << i, {1'h0, ctrl.bias_half});
      end
      wr(BIAS_OFS, 8'h00);
      check_val("all full", 8'h00, {1'h0, ctrl.bias_half});
      wr(BIAS_OFS, 8'h40);
      wr(PWR_CFG_OFS, 8'h00);
      check_val("gen off again", 8'h00, {1'h0, ctrl.bias_half});
      check_val("gen enable again", 8'h00, {7'h00, ctrl.bias_gen_en});
   endtask

   task automatic t_gain();
      logic [7:0] exp_b;
      wr(GAIN_A_OFS, 8'hFF);
      rd_check("gain a reg", GAIN_A_OFS, 8'h3F);
      wr(GAIN_B_OFS, 8'h95);
      rd_check("gain b reg", GAIN_B_OFS, 8'h15);
      for (int m = 0; m < 8; m++)
      begin
         wr(GAIN_MODE_OFS, 8'(m));
         exp_b = m[1] ? 8'h00 : 8'h15;
         check_val("exp mode", {6'h00, 2'(m)}, {6'h00, ctrl.exp_gain_mode});
         check_val("wb mode", {7'h00, m[2]}, {7'h00, ctrl.wb_linear});
         check_val("code a", 8'h3F, {2'h0, ctrl.global_gain_code_a});
         check_val("code b", exp_b, {2'h0, ctrl.global_gain_code_b});
      end
      wr(GAIN_MODE_OFS, 8'hFF);
      rd_check("mode reg", GAIN_MODE_OFS, 8'h07);
   endtask

   task automatic t_refused();
      logic a;
      u_afe_host_model.wr_reg(DEV ^ 7'h01, GAIN_A_OFS, 8'h01, a);
      check_val("foreign ack", 8'h00, {7'h00, a});
      rd_check("gain a kept", GAIN_A_OFS, 8'h3F);
      wr(8'h30, 8'hA5);
      rd_check("unmapped", 8'h30, 8'h00);
   endtask

   // A reset in mid-run, with the bus idle, must bring back the gain A and B codes and the exposure mode.
   task automatic t_mid_reset();
      nrst <= 1'b0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      check_val("gain a after rst", 8'h0E, {2'h0, ctrl.global_gain_code_a});
      check_val("gain b after rst", 8'h0E, {2'h0, ctrl.global_gain_code_b});
      check_val("mode after rst", 8'h00, {6'h00, ctrl.exp_gain_mode});
      rd_check("gain a reg rst", GAIN_A_OFS, 8'h0E);
      rd_check("gain b reg rst", GAIN_B_OFS, 8'h0E);
   endtask

   // ************************************************************
   // Main sequence and hang guard
   // ************************************************************
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         mismatches++;
         complete_run();
      end
   end

   initial
   begin
      nrst = 1'b0;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset_values();
      t_tristate();
      t_bias();
      t_gain();
      t_refused();
      t_mid_reset();
      complete_run();
   end
endmodule // tb
